// ### acu_chk.sv
// port assertions for the analog compare unit
`timescale 1ns/10ps
module acu_chk (
   input wire        SYS_CLK,
   input wire        ARST_N,
   input wire        HSEL,
   input wire [31:0] HADDR,
   input wire [1:0]  HTRANS,
   input wire        HWRITE,
   input wire [31:0] HWDATA,
   input wire        HREADY,
   input wire [31:0] HRDATA,
   input wire        HREADYOUT,
   input wire        HRESP,
   input wire        CMP_RAW,
   input wire        TIMER_CH0_PIN_IN,
   input wire        REF_SELECT,
   input wire        BANDGAP_BUFFER_EN,
   input wire        COMPARE_OUT_PIN,
   input wire        COMPARE_OUT_OE,
   input wire        TIMER_CH0_CAPTURE,
   input wire        TIMER_CH0_PIN_CONNECT,
   input wire        WAKE_REQ
);
   reg       rd_v;
   reg [7:0] rd_a;
   reg       wr_v;
   reg       en_s;
   wire      rd0 = rd_v && rd_a == 8'h00;
   // remember a read address phase so its data phase can be judged
   always @(posedge SYS_CLK or negedge ARST_N)
      if (!ARST_N) begin
         rd_v <= 1'b0;
         rd_a <= 8'h00;
         wr_v <= 1'b0;
         en_s <= 1'b0;
      end else begin
         rd_v <= HSEL && HREADY && HTRANS == 2'h2 && !HWRITE;
         rd_a <= HADDR[7:0];
         wr_v <= HSEL && HREADY && HTRANS == 2'h2 && HWRITE;
         // shadow of the enable bit, taken at the end of a control write
         if (wr_v && rd_a == 8'h00)
            en_s <= HWDATA[7];
      end
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!ARST_N);
   a_bus_okay: assert property (HREADYOUT && !HRESP) else $error("bus not ready or not okay");
   a_pin_gated: assert property (COMPARE_OUT_PIN |-> CMP_RAW && COMPARE_OUT_OE)
      else $error("output pin driven without cause");
   a_oe_ctrl: assert property (rd0 |-> COMPARE_OUT_OE == (HRDATA[7] & HRDATA[2]))
      else $error("output enable disagrees with control");
   a_ref_ctrl: assert property (rd0 |-> REF_SELECT == HRDATA[6])
      else $error("reference select disagrees with control");
   a_level_off: assert property (rd0 && !HRDATA[7] |-> !HRDATA[3])
      else $error("level nonzero while disabled");
   a_wake_cause: assert property (rd0 && WAKE_REQ |-> HRDATA[7] && HRDATA[4])
      else $error("wake request without enables");
   a_route_ctrl: assert property (rd_v && rd_a == 8'h04 |->
      TIMER_CH0_PIN_CONNECT == !HRDATA[0]) else $error("pin connect disagrees with route");
   a_bg_ctrl: assert property (rd_v && rd_a == 8'h08 |-> BANDGAP_BUFFER_EN == HRDATA[0])
      else $error("buffer enable disagrees with register");
   a_route_cap: assert property ((!TIMER_CH0_PIN_CONNECT && CMP_RAW && en_s)[*3]
      |-> TIMER_CH0_CAPTURE) else $error("capture does not follow comparator");
   a_route_low: assert property ((!TIMER_CH0_PIN_CONNECT && !CMP_RAW)[*3]
      |-> !TIMER_CH0_CAPTURE) else $error("capture high while comparator low");
   a_pin_cap: assert property ((TIMER_CH0_PIN_CONNECT && !TIMER_CH0_PIN_IN)[*3]
      |-> !TIMER_CH0_CAPTURE) else $error("capture does not follow pin");
   c_flag_read: cover property (rd0 && HRDATA[5]);
   c_routed: cover property (!TIMER_CH0_PIN_CONNECT && TIMER_CH0_CAPTURE);
   c_pin_out: cover property (COMPARE_OUT_PIN);
   c_wake: cover property (WAKE_REQ);
endmodule
bind acu_top acu_chk acu_chk_i (.*);

// ### acu_cmp_model.sv
// behavioural comparator with bandgap reference on the far side of the unit
`timescale 1ns/10ps
module acu_cmp_model #(
   parameter BG_MV = 1200
) (
   // settings from the unit
   input wire        ref_select,
   input wire        bandgap_buffer_en,
   // analog levels in millivolts
   input wire [15:0] pos_mv,
   input wire [15:0] neg_mv,
   // result
   output wire       cmp_raw
);
   wire [15:0] non_inv;
   // an unbuffered bandgap gives no usable level, so it reads as ground
   assign non_inv = ref_select ? (bandgap_buffer_en ? BG_MV : 16'h0000) : pos_mv;
   assign cmp_raw = non_inv > neg_mv;
endmodule

// ### acu_regs.vh
// register map and constants of the analog compare unit
// What this block does
// - enabled unit keeps comparing and detecting events in light stop state.
// - in light stop, output pin keeps driving result when pin enable set.
// - event in stop with irq enable sets flag and requests wake-up.
// - leaving stop by reset returns all control and status to reset values.
// - deep and deepest stop power unit down; wake-up leaves it in reset. The code has only the LIGHT_STOP input and never powers the unit down.
// - enabled unit runs in wait; event with irq enable wakes system.
// - background debug mode does not freeze comparison, flag or output.
// - capture route select feeds comparator output to timer capture channel 0.
// - capture route select disconnects timer channel 0 from its pin.
// - event selectable as rising, falling or either edge.
// - reference select swaps the bandgap in for the positive input pin.
// - result drives the output pin only when output pin enable is set.
// - edge field 00 falling, 01 rising, 10 falling, 11 either edge.
// - event flag set by event, cleared only by writing one.
// - level bit reads live output, reads 0 while unit disabled.
// - interrupt request while flag and irq enable are both set.
`ifndef ACU_REGS_VH
`define ACU_REGS_VH
`define ACU_ADDR_CTRL     4'h0
`define ACU_ADDR_SYSOPT   4'h4
`define ACU_ADDR_PWR      4'h8
`define ACU_BIT_ENABLE    7
`define ACU_BIT_REFSEL    6
`define ACU_BIT_FLAG      5
`define ACU_BIT_IRQEN     4
`define ACU_BIT_LEVEL     3
`define ACU_BIT_OPE       2
`define ACU_BIT_ROUTE     0
`define ACU_BIT_BANDGAP_BUFFER_ENABLE      0
`define ACU_MODE_FALL0    2'h0
`define ACU_MODE_RISE     2'h1
`define ACU_MODE_FALL2    2'h2
`define ACU_MODE_BOTH     2'h3
`define ACU_CTRL_RST      8'h00
`define ACU_HTRANS_NONSEQ 2'h2
`endif

// ### acu_top.v
// analog compare unit control logic with AHB-Lite register slave
`timescale 1ns/10ps
module acu_top (
   // clock and reset
   SYS_CLK,
   ARST_N,
   // ahb-lite slave
   HSEL,
   HADDR,
   HTRANS,
   HWRITE,
   HSIZE,
   HWDATA,
   HREADY,
   HRDATA,
   HREADYOUT,
   HRESP,
   // power state
   LIGHT_STOP,
   // analog side
   CMP_RAW,
   REF_SELECT,
   BANDGAP_BUFFER_EN,
   // pins and timer
   COMPARE_OUT_PIN,
   COMPARE_OUT_OE,
   TIMER_CH0_PIN_IN,
   TIMER_CH0_CAPTURE,
   TIMER_CH0_PIN_CONNECT,
   // system
   IRQ,
   WAKE_REQ
);
`include "acu_regs.vh"
   input  wire        SYS_CLK;
   input  wire        ARST_N;
   input  wire        HSEL;
   input  wire [31:0] HADDR;
   input  wire [1:0]  HTRANS;
   input  wire        HWRITE;
   input  wire [2:0]  HSIZE;
   input  wire [31:0] HWDATA;
   input  wire        HREADY;
   output reg  [31:0] HRDATA;
   output wire        HREADYOUT;
   output wire        HRESP;
   input  wire        LIGHT_STOP;
   input  wire        CMP_RAW;
   output wire        REF_SELECT;
   output wire        BANDGAP_BUFFER_EN;
   output wire        COMPARE_OUT_PIN;
   output wire        COMPARE_OUT_OE;
   input  wire        TIMER_CH0_PIN_IN;
   output wire        TIMER_CH0_CAPTURE;
   output wire        TIMER_CH0_PIN_CONNECT;
   output wire        IRQ;
   output wire        WAKE_REQ;

   reg         enable_reg;
   reg         refsel_reg;
   reg         flag_reg;
   reg         irqen_reg;
   reg         ope_reg;
   reg  [1:0]  mode_reg;
   reg         route_reg;
   reg         bandgap_buffer_enable_reg;
   reg         sync1_reg;
   reg         sync2_reg;
   reg         prev_reg;
   reg         deepest_stop_state_reg;
   reg         deep_stop_state_reg;
   reg         pin1_reg;
   reg         pin2_reg;
   reg         wr_pend_reg;
   reg         rd_pend_reg;
   reg  [3:0]  addr_reg;
   reg         wclr_n_reg;
   wire        take;
   wire        event_now;
   wire        wake_seen;
   wire        flag_next;
   wire        wr_ctrl;
   wire        level;

   // async reset returns all state; any reset-driven stop exit lands here
   assign take = HSEL && HREADY && (HTRANS == `ACU_HTRANS_NONSEQ);
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;

   // address phase capture; zero-wait data phase
   always @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg    <= 4'h0;
      end else begin
         wr_pend_reg <= take && HWRITE;
         rd_pend_reg <= take && !HWRITE;
         if (take)
            addr_reg <= HADDR[3:0];
      end
   end

   always @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg  <= 1'b0;
         deepest_stop_state_reg <= 1'b0;
         deep_stop_state_reg <= 1'b0;
         pin1_reg  <= 1'b0;
         pin2_reg  <= 1'b0;
      end else begin
         sync1_reg <= CMP_RAW;
         sync2_reg <= sync1_reg;
         prev_reg  <= enable_reg ? sync2_reg : 1'b0;
         deepest_stop_state_reg <= LIGHT_STOP;
         deep_stop_state_reg <= deepest_stop_state_reg;
         pin1_reg  <= TIMER_CH0_PIN_IN;
         pin2_reg  <= pin1_reg;
      end
   end

   assign level = enable_reg & sync2_reg;

   // edge event by mode; no freeze input exists
   assign event_now = enable_reg && prev_reg != level &&
                      ((mode_reg == `ACU_MODE_BOTH) ||
                       (mode_reg == `ACU_MODE_RISE && level) ||
                       ((mode_reg == `ACU_MODE_FALL0 || mode_reg == `ACU_MODE_FALL2) &&
                        !level));

   // asynchronous catcher armed only while in light stop
   always @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N)
         wclr_n_reg <= 1'b0;
      else
         wclr_n_reg <= deep_stop_state_reg;
   end

   acu_wake_latch u_wake (
      .arm     (enable_reg & LIGHT_STOP),
      .mode    (mode_reg),
      .clear_n (wclr_n_reg),
      .cmp_raw (CMP_RAW),
      .seen    (wake_seen)
   );

   // wake request while stopped or waiting with irq enabled
   assign WAKE_REQ = irqen_reg && enable_reg && (wake_seen || flag_reg);

   assign wr_ctrl = wr_pend_reg && (addr_reg == `ACU_ADDR_CTRL);

   // set wins over write-one clear; stop edge sets flag while delayed stop state is high
   assign flag_next = event_now || (wake_seen && deep_stop_state_reg) ||
                      (flag_reg && !(wr_ctrl && HWDATA[`ACU_BIT_FLAG]));

   always @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         enable_reg <= 1'b0;
         refsel_reg <= 1'b0;
         flag_reg   <= 1'b0;
         irqen_reg  <= 1'b0;
         ope_reg    <= 1'b0;
         mode_reg   <= `ACU_MODE_FALL0;
         route_reg  <= 1'b0;
         bandgap_buffer_enable_reg   <= 1'b0;
      end else begin
         flag_reg <= flag_next;
         if (wr_ctrl) begin
            enable_reg <= HWDATA[`ACU_BIT_ENABLE];
            refsel_reg <= HWDATA[`ACU_BIT_REFSEL];
            irqen_reg  <= HWDATA[`ACU_BIT_IRQEN];
            ope_reg    <= HWDATA[`ACU_BIT_OPE];
            mode_reg   <= HWDATA[1:0];
         end
         if (wr_pend_reg && addr_reg == `ACU_ADDR_SYSOPT)
            route_reg <= HWDATA[`ACU_BIT_ROUTE];
         if (wr_pend_reg && addr_reg == `ACU_ADDR_PWR)
            bandgap_buffer_enable_reg <= HWDATA[`ACU_BIT_BANDGAP_BUFFER_ENABLE];
      end
   end

   // read data; unmapped addresses read zero
   always @* begin
      HRDATA = 32'h0000_0000;
      if (rd_pend_reg) begin
         case (addr_reg)
            `ACU_ADDR_CTRL:
               HRDATA = {24'h000000, enable_reg, refsel_reg, flag_reg, irqen_reg,
                         level, ope_reg, mode_reg};
            `ACU_ADDR_SYSOPT:
               HRDATA = {31'h00000000, route_reg};
            `ACU_ADDR_PWR:
               HRDATA = {31'h00000000, bandgap_buffer_enable_reg};
            default:
               HRDATA = 32'h0000_0000;
         endcase
      end
   end

   // reference select steers the analog mux
   assign REF_SELECT = refsel_reg;
   assign BANDGAP_BUFFER_EN = bandgap_buffer_enable_reg;
   // output pin driven only with pin enable, stop or not
   assign COMPARE_OUT_OE  = enable_reg & ope_reg;
   assign COMPARE_OUT_PIN = COMPARE_OUT_OE & CMP_RAW;
   assign TIMER_CH0_CAPTURE = route_reg ? level : pin2_reg;
   assign TIMER_CH0_PIN_CONNECT = ~route_reg;
   assign IRQ = flag_reg & irqen_reg;
endmodule

// ### acu_wake_latch.v
// asynchronous edge catcher for wake-up while the bus clock is stopped
`timescale 1ns/10ps
module acu_wake_latch (
   // control
   arm,
   mode,
   clear_n,
   // comparator
   cmp_raw,
   // result
   seen
);
`include "acu_regs.vh"
   input  wire       arm;
   input  wire [1:0] mode;
   input  wire       clear_n;
   input  wire       cmp_raw;
   output wire       seen;
   reg               rise_reg;
   reg               fall_reg;
   // edges caught with the comparator as clock; cleared from the bus domain
   always @(posedge cmp_raw or negedge clear_n) begin
      if (!clear_n)
         rise_reg <= 1'b0;
      else if (arm)
         rise_reg <= 1'b1;
   end
   always @(negedge cmp_raw or negedge clear_n) begin
      if (!clear_n)
         fall_reg <= 1'b0;
      else if (arm)
         fall_reg <= 1'b1;
   end
   assign seen = (rise_reg && (mode == `ACU_MODE_RISE || mode == `ACU_MODE_BOTH)) ||
                 (fall_reg && (mode != `ACU_MODE_RISE));
endmodule

// ### tb.sv
// self-checking testbench for the analog compare unit
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
   reg SYS_CLK = 0, ARST_N = 0, LIGHT_STOP = 0, PIN_IN = 0, HWRITE = 0;
   reg [1:0] HTRANS = 0;
   reg [31:0] HADDR = 0, HWDATA = 0, r;
   reg [15:0] pos = 16'h0064, neg = 16'h01F4;
   wire RDY, cmp, refs, bandgap_buffer_enable, opin, oe, cap, conn, irq, wake;
   wire [31:0] HRDATA;
   integer errors = 0, comparisons = 0, m;
   acu_top acu_top_i (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .HSEL(1'b1), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(RDY),
      .HRDATA(HRDATA), .HREADYOUT(RDY), .HRESP(), .LIGHT_STOP(LIGHT_STOP), .CMP_RAW(cmp),
      .REF_SELECT(refs), .BANDGAP_BUFFER_EN(bandgap_buffer_enable), .COMPARE_OUT_PIN(opin),
      .COMPARE_OUT_OE(oe), .TIMER_CH0_PIN_IN(PIN_IN), .TIMER_CH0_CAPTURE(cap),
      .TIMER_CH0_PIN_CONNECT(conn), .IRQ(irq), .WAKE_REQ(wake));
   acu_cmp_model acu_cmp_model_i (.ref_select(refs), .bandgap_buffer_en(bandgap_buffer_enable),
      .pos_mv(pos), .neg_mv(neg), .cmp_raw(cmp));
   initial forever #2 SYS_CLK = ~SYS_CLK;
   task print_verdict;
      begin
         $display("errors=%0d comparisons=%0d", errors, comparisons);
         if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task wait_rdy;
      integer n;
      begin
         n = 0;
         @(posedge SYS_CLK);
         while (RDY !== 1'b1 && n < 20) begin n++; @(posedge SYS_CLK); end
         if (n == 20) begin errors++; print_verdict; end
      end
   endtask
   task xfer(input [7:0] a, input w, input [31:0] d);
      begin
         HADDR <= {24'h0, a}; HWRITE <= w; HTRANS <= 2'h2;
         wait_rdy;
         HTRANS <= 2'h0; HWDATA <= d;
         wait_rdy;
         r = HRDATA;
      end
   endtask
   task cyc(input integer n); repeat (n) @(posedge SYS_CLK); endtask
   task t_reset_vals;
      begin
         xfer(8'h0C, 1, 32'hFF); xfer(8'h0C, 0, 0); `CHK(r, 32'h0)
         xfer(8'h00, 0, 0); `CHK(r, 32'h0)
         xfer(8'h04, 0, 0); `CHK(r, 32'h0)
         `CHK({conn, irq, oe, wake}, 4'h8)
      end
   endtask
   task t_edges;
      begin
         for (m = 0; m < 4; m++) begin
            xfer(8'h00, 1, 32'hB0 | m); pos <= 16'h0320; cyc(5);
            `CHK(irq, m[0])
            xfer(8'h00, 1, 32'h90 | m); xfer(8'h00, 0, 0);
            `CHK(r[5], m[0])
            xfer(8'h00, 1, 32'hB0 | m);
            pos <= 16'h0064; cyc(5); xfer(8'h00, 0, 0);
            `CHK(r[5], m != 1)
         end
      end
   endtask
   task t_level_pin;
      begin
         xfer(8'h08, 1, 1); xfer(8'h00, 1, 32'hE4); cyc(4);
         xfer(8'h00, 0, 0); `CHK(r[3], 1'b1)
         `CHK({opin, oe}, 2'h3)
         xfer(8'h00, 1, 32'h80); pos <= 16'h0320; cyc(4); `CHK({opin, oe}, 2'h0)
         xfer(8'h00, 1, 32'h00); xfer(8'h00, 0, 0); `CHK(r[3], 1'b0)
      end
   endtask
   task t_route;
      begin
         xfer(8'h00, 1, 32'h80);
         xfer(8'h04, 1, 1); cyc(4); `CHK({conn, cap}, 2'h1)
         xfer(8'h04, 1, 0); PIN_IN <= 1'b0; cyc(4); `CHK({conn, cap}, 2'h2)
         PIN_IN <= 1'b1; cyc(4); `CHK({conn, cap}, 2'h3)
         PIN_IN <= 1'b0;
      end
   endtask
   task t_stop;
      begin
         xfer(8'h00, 1, 32'hB5); pos <= 16'h0064; cyc(4); LIGHT_STOP <= 1'b1; cyc(4);
         pos <= 16'h0320; cyc(2); `CHK({wake, opin}, 2'h3)
         LIGHT_STOP <= 1'b0; cyc(8); xfer(8'h00, 0, 0); `CHK(r[5], 1'b1)
         ARST_N <= 1'b0; cyc(2); ARST_N <= 1'b1; cyc(1); t_reset_vals;
      end
   endtask
   initial begin
      cyc(2); ARST_N <= 1'b1; cyc(1);
      t_reset_vals; t_edges; t_level_pin; t_route; t_stop;
      print_verdict;
   end
endmodule
